// [rtl/apt_defines.svh]
// Timing constants, command codes and figures for the bank auto-close timing block
//
// Behaviour
// - Read with cmd_bit0_falling high engages auto close
// - Read auto close starts at max(BL/2, BL/2-2+RTP)
// - Different-bank same-kind commands seamless at BL/2
// - Close period timed from latest precharge
// - Array writes start per complete 4-word group
// - Flag low leaves bank open after burst
`ifndef APT_DEFINES_SVH
`define APT_DEFINES_SVH

`define APT_NBANK           8
`define APT_BL              5'h08
`define APT_WL              4'h3
`define APT_PREFETCH        3'h4
`define APT_TCK_PS          8000
`define APT_RTP_PS          7500
`define APT_WR_PS           15000
`define APT_RPPB_PS         18000
`define APT_RPAB_PS         21000
`define APT_RTP_CLK         (((`APT_RTP_PS) + (`APT_TCK_PS) - 1) / (`APT_TCK_PS))
`define APT_WR_CLK          (((`APT_WR_PS) + (`APT_TCK_PS) - 1) / (`APT_TCK_PS))
`define APT_RPPB_CLK        (((`APT_RPPB_PS) + (`APT_TCK_PS) - 1) / (`APT_TCK_PS))
`define APT_RPAB_CLK        (((`APT_RPAB_PS) + (`APT_TCK_PS) - 1) / (`APT_TCK_PS))
`define APT_CMD_NOP         3'h0
`define APT_CMD_ACT         3'h1
`define APT_CMD_RD          3'h2
`define APT_CMD_WR          3'h3
`define APT_CMD_PRE         3'h4
`define APT_CMD_PREA        3'h5
`define APT_CMD_BST         3'h6

`endif

// [rtl/apt_pkg.sv]
// Types for the bank auto-close timing block
package apt_pkg;

   typedef struct packed {
      logic [2:0] op;      // Command code
      logic [2:0] bank;    // Target bank
      logic       flag;    // cmd_bit0_falling level
   } apt_cmd_t;

   typedef enum logic [1:0] {
      APT_IDLE  = 2'b00,
      APT_OPEN  = 2'b01,
      APT_BURST = 2'b10,
      APT_CLOSE = 2'b11
   } apt_bstate_t;

   typedef struct packed {
      apt_bstate_t st;      // Bank state
      logic        auto_cl; // Burst ends in auto close
      logic        is_wr;   // Burst is a write
      logic [4:0]  cnt;     // Cycles left in phase
   } apt_bank_t;

endpackage : apt_pkg

// [rtl/apt_core.sv]
// Bank auto-close timing engine: decodes commands on link clock edges
`timescale 1ns/100ps
`include "apt_defines.svh"

module apt_core
(
   input  wire logic                          mclk_i,       // System clock, 100 MHz
   input  wire logic                          resetn_i,     // Synchronous reset, active low
   input  wire logic                          link_clk_i,   // Memory link clock from controller
   input  wire apt_pkg::apt_cmd_t             cmd_i,        // Command sampled at link edge
   input  wire logic                          wdata_vld_i,  // One write word latched
   output logic [`APT_NBANK-1:0]              bank_open_o,  // Row open per bank
   output logic [`APT_NBANK-1:0]              closing_o,    // Close period running per bank
   output logic                               close_start_o,// Auto close began this edge
   output logic                               arr_wr_o,     // Array write of a full group
   output logic                               illegal_o     // Command flagged: bank busy (activate still applied), or read/write to an idle bank
);

   ////////////////////////////////////////////////////////////////////////////
   localparam logic [4:0] BLH   = 5'(`APT_BL / 2);
   localparam int         RTPC  = (`APT_RTP_CLK > 2) ? `APT_RTP_CLK : 2;
   localparam logic [4:0] RDCL  = 5'(`APT_BL / 2 + RTPC - 2);
   localparam logic [4:0] WRCL  = 5'(`APT_WL + `APT_BL / 2 + `APT_WR_CLK + 1);
   localparam logic [4:0] RPPB  = 5'(`APT_RPPB_CLK);
   localparam logic [4:0] RPAB  = 5'(`APT_RPAB_CLK);

   typedef struct packed {
      logic [2:0]          lk_sync;  // Link clock synchroniser and edge history
      apt_pkg::apt_cmd_t   cmd_s1;
      apt_pkg::apt_cmd_t   cmd_s2;
      logic                wv_s1;
      logic                wv_s2;
      logic                wv_s3;
      logic [1:0]          grp_cnt;
      apt_pkg::apt_bank_t [`APT_NBANK-1:0] bk;
      logic                cls_ff;
      logic                arr_ff;
      logic                ill_ff;
   } apt_state_t;

   apt_state_t st_ff;
   apt_state_t nxt_st;

   ////////////////////////////////////////////////////////////////////////////
   // Next state; commands act only on a rising link edge seen through the sync
   always_comb
   begin
      logic lk_rise;
      logic hit;
      lk_rise = 1'b0;
      hit     = 1'b0;
      nxt_st  = st_ff;
      nxt_st.lk_sync = {st_ff.lk_sync[1:0], link_clk_i};
      nxt_st.cmd_s1  = cmd_i;
      nxt_st.cmd_s2  = st_ff.cmd_s1;
      nxt_st.wv_s1   = wdata_vld_i;
      nxt_st.wv_s2   = st_ff.wv_s1;
      nxt_st.wv_s3   = st_ff.wv_s2;
      nxt_st.cls_ff  = 1'b0;
      nxt_st.arr_ff  = 1'b0;
      nxt_st.ill_ff  = 1'b0;
      lk_rise = st_ff.lk_sync[1] & ~st_ff.lk_sync[2];
      // Words counted on a rising edge of the synced strobe; group of four commits
      if (st_ff.wv_s2 & ~st_ff.wv_s3)
      begin
         nxt_st.grp_cnt = st_ff.grp_cnt + 2'h1;
         nxt_st.arr_ff  = (st_ff.grp_cnt == 2'(`APT_PREFETCH - 1));
      end
      // Per-bank timers run on link edges only
      for (int b = 0; b < `APT_NBANK; b++)
      begin
         if (lk_rise && st_ff.bk[b].cnt != 5'h00)
            nxt_st.bk[b].cnt = st_ff.bk[b].cnt - 5'h01;
         if (lk_rise && st_ff.bk[b].cnt == 5'h01)
         begin
            unique case (st_ff.bk[b].st)
               apt_pkg::APT_BURST:
               begin
                  if (st_ff.bk[b].auto_cl)
                  begin
                     nxt_st.bk[b].st  = apt_pkg::APT_CLOSE;
                     nxt_st.bk[b].cnt = RPPB;
                     nxt_st.cls_ff    = 1'b1;
                  end
                  else
                     nxt_st.bk[b].st  = apt_pkg::APT_OPEN;
               end
               apt_pkg::APT_CLOSE: nxt_st.bk[b].st = apt_pkg::APT_IDLE;
               apt_pkg::APT_IDLE, apt_pkg::APT_OPEN: ;
            endcase
         end
      end
      // Command decode
      if (lk_rise)
      begin
         hit = (st_ff.bk[st_ff.cmd_s2.bank].st == apt_pkg::APT_BURST) &&
               st_ff.bk[st_ff.cmd_s2.bank].auto_cl;
         case (st_ff.cmd_s2.op)
            `APT_CMD_ACT:
            begin
               nxt_st.bk[st_ff.cmd_s2.bank].st  = apt_pkg::APT_OPEN;
               nxt_st.ill_ff = st_ff.bk[st_ff.cmd_s2.bank].st != apt_pkg::APT_IDLE;
            end
            `APT_CMD_RD, `APT_CMD_WR:
            begin
               // Reads and writes into an auto-closing bank are flagged, not executed
               if (hit || st_ff.bk[st_ff.cmd_s2.bank].st == apt_pkg::APT_IDLE)
                  nxt_st.ill_ff = 1'b1;
               else
               begin
                  nxt_st.bk[st_ff.cmd_s2.bank].st      = apt_pkg::APT_BURST;
                  nxt_st.bk[st_ff.cmd_s2.bank].auto_cl = st_ff.cmd_s2.flag;
                  nxt_st.bk[st_ff.cmd_s2.bank].is_wr   = (st_ff.cmd_s2.op == `APT_CMD_WR);
                  nxt_st.bk[st_ff.cmd_s2.bank].cnt     =
                     (st_ff.cmd_s2.op == `APT_CMD_WR) ? WRCL :
                     ((RDCL > BLH) ? RDCL : BLH);
               end
            end
            `APT_CMD_BST:
               nxt_st.ill_ff = hit;
            `APT_CMD_PRE, `APT_CMD_PREA:
            begin
               // Latest precharge restarts each affected bank's close period
               for (int b = 0; b < `APT_NBANK; b++)
                  if (st_ff.cmd_s2.op == `APT_CMD_PREA || st_ff.cmd_s2.bank == 3'(b))
                  begin
                     if (st_ff.bk[b].st != apt_pkg::APT_IDLE || st_ff.bk[b].cnt != 5'h00)
                     begin
                        nxt_st.bk[b].st      = apt_pkg::APT_CLOSE;
                        nxt_st.bk[b].auto_cl = 1'b0;
                        nxt_st.bk[b].cnt     = (st_ff.cmd_s2.op == `APT_CMD_PREA) ? RPAB : RPPB;
                     end
                  end
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs from flops
   for (genvar g = 0; g < `APT_NBANK; g++)
   begin : g_out
      assign bank_open_o[g] = (st_ff.bk[g].st == apt_pkg::APT_OPEN) || (st_ff.bk[g].st == apt_pkg::APT_BURST);
      assign closing_o[g]   = (st_ff.bk[g].st == apt_pkg::APT_CLOSE);
   end
   assign close_start_o = st_ff.cls_ff;
   assign arr_wr_o      = st_ff.arr_ff;
   assign illegal_o     = st_ff.ill_ff;

endmodule : apt_core

// [verif/apt_core_asserts.sv]
// Checker for the bank auto-close timing block
`timescale 1ns/100ps
`include "apt_defines.svh"
module apt_core_asserts
(
   input wire logic                  mclk_i,        // Clock
   input wire logic                  resetn_i,      // Reset, low
   input wire logic                  link_clk_i,    // Link clock
   input wire apt_pkg::apt_cmd_t     cmd_i,         // Command
   input wire logic                  wdata_vld_i,   // Write word
   input wire logic [`APT_NBANK-1:0] bank_open_o,   // Open rows
   input wire logic [`APT_NBANK-1:0] closing_o,     // Closing banks
   input wire logic                  close_start_o, // Close began
   input wire logic                  arr_wr_o,      // Group write
   input wire logic                  illegal_o      // Refused command
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   ////////////////////////////////////////////////////////////////////////
   // Raw link rise carrying a read with the close flag
   sequence s_rd_auto;
      $rose(link_clk_i) && cmd_i.op == `APT_CMD_RD && cmd_i.flag;
   endsequence
   // Three link periods are 37.5 cycles; sync jitter widens the end
   sequence s_close_run;
      (closing_o[0] throughout ##34 1'b1) ##[1:6] !closing_o[0];
   endsequence
   a_reset_quiet: assert property (disable iff (1'b0) !resetn_i |=> !bank_open_o && !closing_o && !close_start_o)
      else $error("outputs not clear after reset");
   a_read_close: assert property (s_rd_auto |-> ##[48:58] close_start_o)
      else $error("auto close not started after four link edges");
   a_close_marks: assert property (close_start_o |-> (closing_o & ~$past(closing_o)) != 0)
      else $error("close start without a new closing bank");
   a_close_length: assert property ($rose(closing_o[0]) |-> s_close_run)
      else $error("close period length wrong");
   a_close_shuts: assert property ($rose(closing_o[0]) |-> !bank_open_o[0])
      else $error("closing bank still open");
   a_start_pulse: assert property (close_start_o |=> !close_start_o)
      else $error("close start longer than one cycle");
   a_group_quiet: assert property (!wdata_vld_i [*8] |=> !arr_wr_o)
      else $error("array write without a new word");
   a_arr_pulse: assert property (arr_wr_o |=> !arr_wr_o)
      else $error("array write longer than one cycle");
   a_refuse_pulse: assert property (illegal_o |=> !illegal_o)
      else $error("refusal longer than one cycle");
endmodule : apt_core_asserts
bind apt_core apt_core_asserts apt_core_asserts_i (.mclk_i, .resetn_i, .link_clk_i, .cmd_i, .wdata_vld_i,
   .bank_open_o, .closing_o, .close_start_o, .arr_wr_o, .illegal_o);

// [verif/apt_ctl_model.sv]
// Memory controller model: link clock, commands and write words
`timescale 1ns/100ps
`include "apt_defines.svh"
module apt_ctl_model
(
   output logic              link_clk_o, // Free-running link clock
   output apt_pkg::apt_cmd_t cmd_o,      // Command, held across link rise
   output logic              wvld_o      // Write word strobe
);
   // A memory clock runs free, 125 ns period
   initial
   begin
      link_clk_o = 1'h0;
      cmd_o = 7'h00;
      wvld_o = 1'h0;
      forever #62.5 link_clk_o = ~link_clk_o;
   end
   // Change on falling edges so setup and hold at the rise are both half a period
   task send(input logic [2:0] op, input logic [2:0] bank, input logic flag, input int gap);
      @(negedge link_clk_o);
      cmd_o <= '{op, bank, flag};
      @(negedge link_clk_o);
      cmd_o <= '{`APT_CMD_NOP, 3'h0, 1'h0};
      repeat (gap) @(negedge link_clk_o); // Caller sets legal spacing
      // Gaps keep bank spacing
      // Gaps keep close spacing
   endtask : send
   // One word per two link cycles
   task words(input int n);
      repeat (n)
      begin
         @(negedge link_clk_o);
         wvld_o <= 1'h1;
         @(negedge link_clk_o);
         wvld_o <= 1'h0;
      end
   endtask : words
endmodule : apt_ctl_model

// [verif/apt_core_bench.sv]
// Self-checking bench for the bank auto-close timing block
`timescale 1ns/100ps
`include "apt_defines.svh"
module apt_core_bench;
   logic                  mclk_i, resetn_i, link_clk, wvld, start_w, arr_w, ill_w; // Design pins
   apt_pkg::apt_cmd_t     cmd;              // Command from model
   logic [`APT_NBANK-1:0] open_w, closing_w; // Bank levels
   int errors, total_checks, cyc, n_start, n_arr, n_ill, n0, i;
   ////////////////////////////////////////////////////////////////////////
   apt_ctl_model apt_ctl_model_i (.link_clk_o(link_clk), .cmd_o(cmd), .wvld_o(wvld));
   apt_core apt_core_i (.mclk_i, .resetn_i, .link_clk_i(link_clk), .cmd_i(cmd), .wdata_vld_i(wvld),
      .bank_open_o(open_w), .closing_o(closing_w), .close_start_o(start_w), .arr_wr_o(arr_w), .illegal_o(ill_w));
   // Clock
   initial
   begin
      mclk_i = 1'h0;
      forever #5 mclk_i = ~mclk_i;
   end
   // Pulse counters; a hang is cut short well past the expected run
   always @(posedge mclk_i)
   begin
      cyc++;
      n_start += (start_w === 1'h1);
      n_arr += (arr_w === 1'h1);
      n_ill += (ill_w === 1'h1);
      if (cyc == 8000)
      begin
         errors++;
         test_done();
      end
   end
   task chk(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'h1)
      begin
         errors++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask : chk
   // Bounded wait for a close start; i keeps the cycles waited
   task wait_start;
      for (i = 0; i < 130 && start_w !== 1'h1; i++)
         @(posedge mclk_i) #1;
   endtask : wait_start
   task t_open;
      n0 = n_ill;
      apt_ctl_model_i.send(`APT_CMD_ACT, 3'h1, 1'h0, 0);
      apt_ctl_model_i.send(`APT_CMD_RD, 3'h1, 1'h0, 8);
      chk(open_w[1] === 1'h1 && closing_w[1] === 1'h0, "plain read closed row");
      apt_ctl_model_i.send(`APT_CMD_RD, 3'h4, 1'h0, 2);
      chk(n_ill - n0 == 1 && open_w[4] === 1'h0, "read to idle bank");
   endtask : t_open
   task t_auto_rd;
      apt_ctl_model_i.send(`APT_CMD_ACT, 3'h0, 1'h0, 4);
      apt_ctl_model_i.send(`APT_CMD_RD, 3'h0, 1'h1, 0);
      wait_start();
      chk(i >= 40 && i <= 55 && closing_w[0] === 1'h1 && open_w[0] === 1'h0, "read close");
      repeat (45) @(posedge mclk_i);
      chk(closing_w[0] === 1'h0, "close period end");
   endtask : t_auto_rd
   // Two auto-close reads BL/2 apart to different banks
   task t_seam;
      n0 = n_start;
      apt_ctl_model_i.send(`APT_CMD_ACT, 3'h2, 1'h0, 0);
      apt_ctl_model_i.send(`APT_CMD_ACT, 3'h3, 1'h0, 3);
      apt_ctl_model_i.send(`APT_CMD_RD, 3'h2, 1'h1, 2);
      apt_ctl_model_i.send(`APT_CMD_RD, 3'h3, 1'h1, 0);
      repeat (120) @(posedge mclk_i);
      chk(n_start - n0 == 2 && closing_w[3:2] === 2'h0, "seamless reads");
   endtask : t_seam
   task t_wr;
      n0 = n_arr;
      apt_ctl_model_i.send(`APT_CMD_ACT, 3'h5, 1'h0, 0);
      apt_ctl_model_i.send(`APT_CMD_WR, 3'h5, 1'h1, 0);
      apt_ctl_model_i.words(3);
      chk(n_arr == n0, "partial group written");
      apt_ctl_model_i.words(1);
      repeat (8) @(posedge mclk_i);
      chk(n_arr - n0 == 1, "full group");
      wait_start();
      chk(closing_w[5] === 1'h1, "write auto close");
   endtask : t_wr
   task test_done;
      $display("errors=%0d checks=%0d", errors, total_checks);
      if (errors == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done
   // Main sequence
   initial
   begin
      resetn_i = 1'h0;
      repeat (4) @(posedge mclk_i);
      #1 resetn_i = 1'h1;
      chk(open_w === '0 && closing_w === '0, "reset state");
      repeat (3) @(posedge mclk_i);
      t_open();
      t_auto_rd();
      t_seam();
      t_wr();
      test_done();
   end
endmodule : apt_core_bench
